// ---- hdl/pdr_keeper.sv ----
// Weak keeper for one input or bidirectional pin.
// Assumes the external level and drive flag are already synchronised.
`timescale 1ns/10ps

module pdr_keeper (
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_own_oe,
  input  wire logic i_own_val,
  input  wire logic i_ext_drv,
  input  wire logic i_ext_val,
  output logic      o_level
);

  // ----------------------------------------------------------------
  // Keeper
  // ----------------------------------------------------------------
  // Any driver overrides the held level; only a floating pin keeps it
  wire logic driven_w = i_own_oe | i_ext_drv;
  wire logic level_nxt = i_own_oe ? i_own_val : i_ext_val;

  logic level_r;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      level_r <= 1'b0;
    end else if (driven_w) begin
      level_r <= level_nxt; // RULE13
    end
  end

  assign o_level = level_r;

endmodule // pdr_keeper

// ---- hdl/pdr_pkg.sv ----
// Constants shared by the power-down and reset block.
// Assumes a single 50 MHz system clock drives all logic.
package pdr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REG = 10;
  localparam int unsigned IDX_W   = 4;
  localparam int unsigned SIG_W   = 64;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned PUR_TIME_TYP_NS = 600;
  localparam int unsigned PUR_TIME_MAX_NS = 1000;
  // Longest time rounds down, never below one cycle
  localparam int unsigned PUR_CYCLES_RAW  =
    PUR_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PUR_CYCLES      =
    (PUR_CYCLES_RAW < 1) ? 1 : PUR_CYCLES_RAW;
  localparam int unsigned PUR_CNT_W       = 7;
  localparam logic [PUR_CNT_W-1:0] PUR_LAST =
    PUR_CNT_W'(PUR_CYCLES - 1);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_REG-1:0] REG_RST = 10'h000;
  localparam logic [SIG_W-1:0]   SIG_RST = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDR_POR   = 2'b00,
    PDR_RUN   = 2'b01,
    PDR_SLEEP = 2'b10
  } pdr_mode_e;

endpackage

// ---- hdl/pdr_top.sv ----
// Registered-output core of a small programmable logic device:
// sleep hold, power-up clear, preload, security fuse, signature and
// pin keepers. Pins arrive asynchronously and are synchronised here;
// the programmer port runs on i_mclk.
`timescale 1ns/10ps

// What this block does
// RULE1 - Sleep pin high enters the hold state, low returns to normal.
// RULE2 - In hold, output data is latched and presented unchanged.
// RULE3 - An output that was high-impedance on entry stays so in hold.
// RULE4 - In hold, clock and input changes are ignored by all registers.
// RULE5 - At power-up every register is cleared low asynchronously.
// RULE6 - Each output level follows its buffer polarity, not the raw bit.
// RULE7 - The board meets setup needs before the first clock edge.
// RULE8 - The board keeps the clock still for the power-up reset time.
// RULE9 - A test preload can force each register high or low.
// RULE10 - A 64-bit user signature is always readable, even secured.
// RULE11 - Once secured, configuration readback and preload are refused.
// RULE12 - The fuse acts at once, so it is programmed as the last step.
// RULE13 - Each pin keeps its last level weakly when nothing drives it.
module pdr_top (
  input  wire logic                        i_mclk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_sleep_pin,
  input  wire logic                        i_clk_pin,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_reg_d,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_oe_pin,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_pol_cfg,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_io_in,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_io_ext_drv,
  input  wire logic                        i_pre_en,
  input  wire logic [pdr_pkg::IDX_W-1:0]   i_pre_idx,
  input  wire logic                        i_pre_val,
  input  wire logic                        i_fuse_prog,
  input  wire logic                        i_rb_req,
  input  wire logic                        i_sig_wr,
  input  wire logic [pdr_pkg::SIG_W-1:0]   i_sig_data,
  output logic [pdr_pkg::NUM_REG-1:0]      o_io_out,
  output logic [pdr_pkg::NUM_REG-1:0]      o_io_oe,
  output logic [pdr_pkg::NUM_REG-1:0]      o_pin_level,
  output logic                             o_sleeping,
  output logic                             o_por_busy,
  output logic                             o_secured,
  output logic                             o_pre_refused,
  output logic                             o_rb_valid,
  output logic                             o_rb_refused,
  output logic [pdr_pkg::NUM_REG-1:0]      o_rb_data,
  output logic [pdr_pkg::SIG_W-1:0]        o_sig_data
);

  localparam int unsigned NR = pdr_pkg::NUM_REG;
  localparam int unsigned SW = 4 * NR + 2;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses in two flops; stage one feeds stage two only
  wire logic [SW-1:0] pins_w = {i_sleep_pin, i_clk_pin, i_reg_d,
                                i_oe_pin, i_pol_cfg, i_io_ext_drv};
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic          clk_prev_r;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      sync1_r    <= pins_w;
      sync2_r    <= sync1_r;
      clk_prev_r <= sync2_r[SW-2];
    end
  end

  // Io levels synchronise separately so the keeper sees clean data
  logic [NR-1:0] io1_r;
  logic [NR-1:0] io2_r;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      io1_r <= '0;
      io2_r <= '0;
    end else begin
      io1_r <= i_io_in;
      io2_r <= io1_r;
    end
  end

  wire logic          sleep_s = sync2_r[SW-1];
  wire logic          clk_s   = sync2_r[SW-2];
  wire logic [NR-1:0] d_s     = sync2_r[4*NR-1:3*NR];
  wire logic [NR-1:0] oe_s    = sync2_r[3*NR-1:2*NR];
  wire logic [NR-1:0] pol_s   = sync2_r[2*NR-1:NR];
  wire logic [NR-1:0] ext_s   = sync2_r[NR-1:0];
  wire logic          clk_rise = clk_s & ~clk_prev_r;

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  pdr_pkg::pdr_mode_e          mode_r;
  pdr_pkg::pdr_mode_e          mode_nxt;
  logic [pdr_pkg::PUR_CNT_W-1:0] pur_cnt_r;

  // Power-up window ends after the longest reset time; the board
  // keeps the clock still meanwhile, and edges are dropped anyway
  wire logic pur_done = (pur_cnt_r == pdr_pkg::PUR_LAST); // RULE8

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      pdr_pkg::PDR_POR: begin
        if (pur_done) begin
          mode_nxt = sleep_s ? pdr_pkg::PDR_SLEEP : pdr_pkg::PDR_RUN;
        end
      end
      pdr_pkg::PDR_RUN: begin
        if (sleep_s) begin
          mode_nxt = pdr_pkg::PDR_SLEEP; // RULE1
        end
      end
      pdr_pkg::PDR_SLEEP: begin
        if (!sleep_s) begin
          mode_nxt = pdr_pkg::PDR_RUN; // RULE1
        end
      end
      default: begin
        mode_nxt = pdr_pkg::PDR_POR;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r    <= pdr_pkg::PDR_POR;
      pur_cnt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      if (mode_r == pdr_pkg::PDR_POR && !pur_done) begin
        pur_cnt_r <= pur_cnt_r + 1'b1;
      end
    end
  end

  wire logic running  = (mode_r == pdr_pkg::PDR_RUN);
  wire logic sleeping = (mode_r == pdr_pkg::PDR_SLEEP);

  // Status ports get flops of their own, loaded from the next mode,
  // so they track mode_r exactly with no decode after the register
  logic sleeping_r;
  logic por_busy_r;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleeping_r <= 1'b0;
      por_busy_r <= 1'b1;
    end else begin
      sleeping_r <= (mode_nxt == pdr_pkg::PDR_SLEEP); // RULE1
      por_busy_r <= (mode_nxt == pdr_pkg::PDR_POR);
    end
  end

  // ----------------------------------------------------------------
  // Security fuse
  // ----------------------------------------------------------------
  // One-way: nothing but reset of the model clears it
  logic secured_r;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      secured_r <= 1'b0;
    end else if (i_fuse_prog) begin
      secured_r <= 1'b1; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Preload decode
  // ----------------------------------------------------------------
  // Refused when secured, and refused during hold to keep state frozen
  wire logic pre_idx_ok = (i_pre_idx < pdr_pkg::IDX_W'(NR));
  wire logic pre_take   = i_pre_en & ~secured_r & ~sleeping &
                          pre_idx_ok; // RULE11
  wire logic pre_refuse = i_pre_en & ~pre_take;
  wire logic [NR-1:0] pre_mask =
    pre_take ? (NR'(1) << i_pre_idx) : '0;

  // ----------------------------------------------------------------
  // Macrocell registers
  // ----------------------------------------------------------------
  // Clock edges count only in run mode; power-up and hold drop them
  logic [NR-1:0] q_r;
  wire logic     clk_take = clk_rise & running; // RULE4
  wire logic [NR-1:0] q_clk = clk_take ? d_s : q_r;
  wire logic [NR-1:0] q_nxt =
    (q_clk & ~pre_mask) | (pre_mask & {NR{i_pre_val}}); // RULE9

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_r <= pdr_pkg::REG_RST; // RULE5
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output buffers
  // ----------------------------------------------------------------
  // Polarity bit set means an inverting buffer
  logic [NR-1:0] out_r;
  logic [NR-1:0] oe_r;
  wire logic [NR-1:0] out_nxt = q_r ^ pol_s; // RULE6

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_r <= '0;
      oe_r  <= '0;
    end else if (!sleeping) begin // RULE2 RULE3
      out_r <= out_nxt;
      oe_r  <= oe_s;
    end
  end
  // Hold freezes both data and enable: RULE2 and RULE3 in one step

  // ----------------------------------------------------------------
  // Pin keepers
  // ----------------------------------------------------------------
  logic [NR-1:0] level_w;

  generate
    for (genvar gi = 0; gi < NR; gi++) begin : g_keep
      pdr_keeper u_keep (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_own_oe  (oe_r[gi]),
        .i_own_val (out_r[gi]),
        .i_ext_drv (ext_s[gi]),
        .i_ext_val (io2_r[gi]),
        .o_level   (level_w[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Readback, signature and status
  // ----------------------------------------------------------------
  logic [NR-1:0]            rb_data_r;
  logic                     rb_valid_r;
  logic                     rb_refused_r;
  logic                     pre_refused_r;
  logic [pdr_pkg::SIG_W-1:0] sig_r;
  wire logic rb_take = i_rb_req & ~secured_r; // RULE11

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rb_data_r     <= '0;
      rb_valid_r    <= 1'b0;
      rb_refused_r  <= 1'b0;
      pre_refused_r <= 1'b0;
    end else begin
      rb_valid_r    <= rb_take;
      rb_refused_r  <= i_rb_req & secured_r;
      pre_refused_r <= pre_refuse;
      if (rb_take) begin
        rb_data_r <= pol_s;
      end
    end
  end

  // Signature writes are a programming step; fuse does not hide it
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sig_r <= pdr_pkg::SIG_RST;
    end else if (i_sig_wr && !secured_r) begin
      sig_r <= i_sig_data;
    end
  end

  assign o_io_out      = out_r;
  assign o_io_oe       = oe_r;
  assign o_pin_level   = level_w;
  assign o_sleeping    = sleeping_r;
  assign o_por_busy    = por_busy_r;
  assign o_secured     = secured_r;
  assign o_pre_refused = pre_refused_r;
  assign o_rb_valid    = rb_valid_r;
  assign o_rb_refused  = rb_refused_r;
  assign o_rb_data     = rb_data_r;
  assign o_sig_data    = sig_r; // RULE10

endmodule // pdr_top

// ---- test/pdr_board.sv ----
// Board-side model: clock pin, array data and external pin levels.
// Assumes requests change on the falling edge of i_mclk.
`timescale 1ns/10ps
module pdr_board (
  input  wire logic                        i_mclk,
  input  wire logic                        i_por_busy,
  input  wire logic                        i_step,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_d,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_drv,
  input  wire logic [pdr_pkg::NUM_REG-1:0] i_val,
  output logic                             o_clk_pin,
  output logic [pdr_pkg::NUM_REG-1:0]      o_reg_d,
  output logic [pdr_pkg::NUM_REG-1:0]      o_io_in
);
  logic [2:0]                  cnt_r  = 3'h0;
  logic [pdr_pkg::NUM_REG-1:0] d_r    = '0;
  logic [pdr_pkg::NUM_REG-1:0] last_r = '0;
  // --------------------------------------------------------------
  // Clock pin and pins
  // --------------------------------------------------------------
  // Data settles two cycles before the clock rises; steps in POR drop
  always @(negedge i_mclk) begin
    if (i_step && cnt_r == 3'h0 && !i_por_busy) begin
      d_r   <= i_d;
      cnt_r <= 3'h6;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
    last_r <= (i_drv & i_val) | (~i_drv & last_r);
  end
  assign o_clk_pin = (cnt_r == 3'h4) || (cnt_r == 3'h3);
  assign o_reg_d   = d_r;
  // A released pin shows the inverse, so only the keeper can hold it
  assign o_io_in   = (i_drv & i_val) | (~i_drv & ~last_r);
endmodule // pdr_board

// ---- test/pdr_props.sv ----
// Port checker for the power-down and reset block.
// Assumes one clock; bound onto every pdr_top below.
`timescale 1ns/10ps
module pdr_props (
  input wire logic                        i_mclk,
  input wire logic                        i_sys_rst,
  input wire logic                        i_sleep_pin,
  input wire logic                        i_pre_en,
  input wire logic                        i_fuse_prog,
  input wire logic                        i_rb_req,
  input wire logic [pdr_pkg::NUM_REG-1:0] o_io_out,
  input wire logic [pdr_pkg::NUM_REG-1:0] o_io_oe,
  input wire logic                        o_sleeping,
  input wire logic                        o_por_busy,
  input wire logic                        o_secured,
  input wire logic                        o_pre_refused,
  input wire logic                        o_rb_valid,
  input wire logic                        o_rb_refused
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  // Reset holds the whole block, so every check is disabled there
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  por_clear_a: assert property ($fell(i_sys_rst) |->
    !o_secured && o_io_oe == '0 && o_por_busy) else $error("bad clear");
  por_window_a: assert property ($fell(i_sys_rst) |->
    o_por_busy[*8] ##42 o_por_busy ##1 !o_por_busy)
    else $error("bad window");
  sleep_enter_a: assert property ($rose(i_sleep_pin) |->
    ##[1:4] o_sleeping) else $error("no hold");
  sleep_exit_a: assert property ($fell(i_sleep_pin) |->
    ##[1:4] !o_sleeping) else $error("no wake");
  hold_frozen_a: assert property (o_sleeping && $past(o_sleeping) |->
    $stable(o_io_out) && $stable(o_io_oe)) else $error("hold moved");
  pre_refused_a: assert property (i_pre_en && o_secured |=>
    o_pre_refused) else $error("preload not refused");
  rb_refused_a: assert property (i_rb_req && o_secured |=>
    o_rb_refused && !o_rb_valid) else $error("readback not refused");
  rb_grant_a: assert property (i_rb_req && !o_secured |=>
    o_rb_valid && !o_rb_refused) else $error("readback lost");
  fuse_sticky_a: assert property (i_fuse_prog || o_secured |=>
    o_secured) else $error("fuse not set");
endmodule // pdr_props

bind pdr_top pdr_props i_props (.*);

// ---- test/testbench.sv ----
// Self-checking bench for the power-down and reset block.
// Assumes pdr_top, pdr_board and the bound checker are compiled.
`timescale 1ns/10ps
module testbench;
  localparam int N = pdr_pkg::NUM_REG;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_sleep_pin = 1'b0, step = 1'b0;
  logic i_pre_en = 1'b0, i_pre_val = 1'b0, i_fuse_prog = 1'b0;
  logic i_rb_req = 1'b0, i_sig_wr = 1'b0;
  logic [3:0] i_pre_idx = 4'h0;
  logic [N-1:0] i_oe_pin = '0, i_pol_cfg = '0, i_io_ext_drv = '0;
  logic [N-1:0] dval = '0, xval = '0, i_reg_d, i_io_in;
  logic [N-1:0] o_io_out, o_io_oe, o_pin_level, o_rb_data;
  logic o_sleeping, o_por_busy, o_secured, o_pre_refused;
  logic o_rb_valid, o_rb_refused, i_clk_pin;
  logic [63:0] i_sig_data = '0, o_sig_data;
  logic [31:0] seed = 32'h0000_433D;
  int error_cnt = 0, checks = 0;
  // --------------------------------------------------------------
  // Plumbing and helpers
  // --------------------------------------------------------------
  always #10 i_mclk = ~i_mclk;
  pdr_top i_dut (.i_mclk, .i_sys_rst, .i_sleep_pin, .i_clk_pin, .i_reg_d,
    .i_oe_pin, .i_pol_cfg, .i_io_in, .i_io_ext_drv, .i_pre_en, .i_pre_idx,
    .i_pre_val, .i_fuse_prog, .i_rb_req, .i_sig_wr, .i_sig_data, .o_io_out,
    .o_io_oe, .o_pin_level, .o_sleeping, .o_por_busy, .o_secured,
    .o_pre_refused, .o_rb_valid, .o_rb_refused, .o_rb_data, .o_sig_data);
  pdr_board i_board (.i_mclk, .i_por_busy(o_por_busy), .i_step(step),
    .i_d(dval), .i_drv(i_io_ext_drv), .i_val(xval), .o_clk_pin(i_clk_pin),
    .o_reg_d(i_reg_d), .o_io_in(i_io_in));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk_sig(input string nm, input logic [63:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_vec(input string nm, input logic [N-1:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk_vec(nm, N'(e), N'(g));
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Eleven cycles cover board setup, clock pulse and pin latency
  task automatic clock_in(input logic [N-1:0] v);
    dval <= v;
    step <= 1'b1;
    cyc(1);
    step <= 1'b0;
    cyc(10);
  endtask
  task automatic preload(input logic [3:0] ix, input logic v, ref_e);
    i_pre_idx <= ix;
    i_pre_val <= v;
    i_pre_en  <= 1'b1;
    cyc(1);
    i_pre_en  <= 1'b0;
    chk_bit("pre_refused", ref_e, o_pre_refused);
    cyc(1);
  endtask
  task automatic rdback(input logic ref_e);
    i_rb_req <= 1'b1;
    cyc(1);
    i_rb_req <= 1'b0;
    chk_bit("rb_refused", ref_e, o_rb_refused);
    chk_bit("rb_valid", ~ref_e, o_rb_valid);
    if (!ref_e) chk_vec("rb_data", i_pol_cfg, o_rb_data);
    cyc(1);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    logic [N-1:0] x;
    logic b;
    i_pol_cfg = N'(rnd());
    cyc(5);
    i_sys_rst <= 1'b0;
    cyc(3);
    chk_vec("out at clear", i_pol_cfg, o_io_out);
    for (int i = 0; i < 60 && o_por_busy !== 1'b0; i++) cyc(1);
    chk_bit("por busy", 1'b0, o_por_busy);
    i_oe_pin <= N'(rnd());
    for (int i = 0; i < 8; i++) begin
      x = (i == 0) ? '1 : N'(rnd());
      clock_in(x);
      chk_vec("out", x ^ i_pol_cfg, o_io_out);
    end
    i_sleep_pin <= 1'b1;
    cyc(5);
    chk_bit("sleeping", 1'b1, o_sleeping);
    i_oe_pin <= ~i_oe_pin;
    preload(4'h0, ~x[0], 1'b1);
    clock_in(~x);
    chk_vec("out held", x ^ i_pol_cfg, o_io_out);
    chk_vec("oe held", ~i_oe_pin, o_io_oe);
    i_sleep_pin <= 1'b0;
    cyc(5);
    chk_bit("awake", 1'b0, o_sleeping);
    clock_in(~x);
    chk_vec("out woken", ~x ^ i_pol_cfg, o_io_out);
    chk_vec("oe woken", i_oe_pin, o_io_oe);
    for (int i = 0; i < 10; i++) begin
      b = 1'(rnd());
      preload(4'(i), b, 1'b0);
      cyc(1);
      chk_bit("preload bit", b ^ i_pol_cfg[i], o_io_out[i]);
    end
    preload(4'hC, 1'b1, 1'b1);
    rdback(1'b0);
    rdback(1'b0);
    i_oe_pin <= '0;
    i_io_ext_drv <= '1;
    xval <= N'(rnd());
    cyc(6);
    chk_vec("pin level", xval, o_pin_level);
    i_io_ext_drv <= '0;
    cyc(6);
    chk_vec("kept level", xval, o_pin_level);
    i_sig_data <= {rnd(), rnd()};
    i_sig_wr <= 1'b1;
    cyc(1);
    i_sig_wr <= 1'b0;
    i_fuse_prog <= 1'b1;
    cyc(1);
    i_fuse_prog <= 1'b0;
    chk_sig("signature", i_sig_data, o_sig_data);
    cyc(1);
    chk_bit("secured", 1'b1, o_secured);
    preload(4'h1, 1'b1, 1'b1);
    rdback(1'b1);
    chk_sig("signature secured", i_sig_data, o_sig_data);
    i_sys_rst <= 1'b1;
    cyc(2);
    i_sys_rst <= 1'b0;
    cyc(1);
    chk_bit("secured cleared", 1'b0, o_secured);
    tally_and_finish();
  end
  // Whole run is under a thousand cycles; twenty thousand means a hang
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // testbench
